// File: hw/signed_arith_flag_unit.sv
// Signed increment, decrement, add and subtract with range flags,
// plus a field decoder for single-precision operands.
// Assumes requests come from execution logic on ref_clk, one per op_valid.
`timescale 1ns/1ps

// Function
// - Negatives are two's complement, built by inverting then adding one.
// - The top bit of an operand is its sign, bit 15 or bit 31.
// - Integer ranges are 16-bit and 32-bit signed.
// - Incrementing past the positive limit wraps to the negative limit and flags it.
// - Decrementing below the negative limit wraps to the positive limit and flags it.
// - Wrap flags are offered as outputs for cascading wider results.
// - Add and subtract use same-width sources and destination and give carry and borrow.
// - Carry is set when the true result is above the positive limit.
// - Borrow is set when the true result is below the negative limit.
// - The destination holds the true result minus the carry weight or plus the borrow weight.
// - A negative true add or subtract result has its sign bit set, also when it sets borrow.
// - A float is sign at 31, exponent at 30..23, fraction at 22..0.
// - The exponent carries a bias of 127 and a set sign means negative.
// - A normalized mantissa has an implied leading one.
// - A normalized float has an exponent strictly between 0 and 255.
// - A 32-bit operand is a low word for bits 15..0 and a high word for 31..16.
module signed_arith_flag_unit
  import arith_flag_pkg::*;
(
  input wire logic ref_clk, // 10 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic op_valid, // Request strobe
  input wire logic [2:0] op_code, // Operation, see op_t
  input wire logic wide, // 1: 32-bit operands
  input wire logic [WORD_W-1:0] src_a_lo, // Source A low word
  input wire logic [WORD_W-1:0] src_a_hi, // Source A high word
  input wire logic [WORD_W-1:0] src_b_lo, // Source B low word
  input wire logic [WORD_W-1:0] src_b_hi, // Source B high word
  output logic [WORD_W-1:0] dst_lo, // Result low word
  output logic [WORD_W-1:0] dst_hi, // Result high word
  output logic result_valid, // Result strobe
  output logic wrap_high_flag, // Increment overflow
  output logic wrap_low_flag, // Decrement underflow
  output logic carry_flag, // Add/sub above range
  output logic borrow_flag, // Add/sub below range
  output logic [3:0] instr_flag_output, // Zero, sign, high, low
  output logic fp_neg, // Float sign
  output logic [7:0] fp_exp, // Float biased exponent
  output logic [9:0] fp_exp_true, // Float unbiased exponent
  output logic fp_normal, // Float is normalized
  output logic [23:0] fp_mant // Float full mantissa
);

  // ----------------------------------------------------------------
  // Operand assembly
  // ----------------------------------------------------------------
  logic [EXT_W-1:0] a_val;
  logic [EXT_W-1:0] b_val;
  logic d_neg;
  logic [7:0] d_exp;
  logic [9:0] d_exp_true;
  logic d_normal;
  logic [23:0] d_mant;

  operand_join #(.OUT_W(EXT_W)) join_a (
    .word_lo(src_a_lo),
    .word_hi(src_a_hi),
    .wide(wide),
    .value(a_val)
  );

  operand_join #(.OUT_W(EXT_W)) join_b (
    .word_lo(src_b_lo),
    .word_hi(src_b_hi),
    .wide(wide),
    .value(b_val)
  );

  float_field_decode fp_dec (
    .fp_word({src_a_hi, src_a_lo}),
    .neg(d_neg),
    .exp_field(d_exp),
    .exp_true(d_exp_true),
    .normal(d_normal),
    .mant(d_mant)
  );

  // ----------------------------------------------------------------
  // Arithmetic and flag evaluation
  // ----------------------------------------------------------------
  op_t op;
  logic [EXT_W-1:0] pos_lim;
  logic [EXT_W-1:0] neg_lim;
  logic [EXT_W-1:0] weight;
  logic [EXT_W-1:0] b_negated;
  logic [EXT_W-1:0] true_val;
  logic [EXT_W-1:0] res_val;
  logic above;
  logic below;

  always_comb begin
    op = op_t'(op_code);
    pos_lim = wide ? POS32 : POS16;
    neg_lim = wide ? NEG32 : NEG16;
    weight = wide ? WT32 : WT16;
    b_negated = ~b_val + ONE34;
    case (op)
      OP_INC: true_val = a_val + ONE34;
      OP_DEC: true_val = a_val - ONE34;
      OP_ADD: true_val = a_val + b_val;
      OP_SUB: true_val = a_val + b_negated;
      default: true_val = ZERO34;
    endcase
    above = $signed(true_val) > $signed(pos_lim);
    below = $signed(true_val) < $signed(neg_lim);
    res_val = true_val;
    case (op)
      OP_INC: if (above) res_val = neg_lim;
      OP_DEC: if (below) res_val = pos_lim;
      OP_ADD, OP_SUB: begin
        if (above) begin
          res_val = true_val - weight;
        end else if (below) begin
          res_val = true_val + weight;
        end
      end
      default: res_val = ZERO34;
    endcase
  end

  // ----------------------------------------------------------------
  // Result and flag registers
  // ----------------------------------------------------------------
  logic [DWORD_W-1:0] dst_reg, dst_next;
  logic valid_reg, valid_next;
  logic high_reg, high_next;
  logic low_reg, low_next;
  logic carry_reg, carry_next;
  logic borrow_reg, borrow_next;
  logic wide_reg, wide_next;
  logic fp_neg_reg, fp_neg_next;
  logic [7:0] fp_exp_reg, fp_exp_next;
  logic [9:0] fp_et_reg, fp_et_next;
  logic fp_norm_reg, fp_norm_next;
  logic [23:0] fp_mant_reg, fp_mant_next;
  logic is_int;

  always_comb begin
    is_int = (op == OP_INC) || (op == OP_DEC) || (op == OP_ADD) || (op == OP_SUB);
    dst_next = dst_reg;
    valid_next = op_valid;
    high_next = high_reg;
    low_next = low_reg;
    carry_next = carry_reg;
    borrow_next = borrow_reg;
    wide_next = wide_reg;
    fp_neg_next = fp_neg_reg;
    fp_exp_next = fp_exp_reg;
    fp_et_next = fp_et_reg;
    fp_norm_next = fp_norm_reg;
    fp_mant_next = fp_mant_reg;
    if (op_valid && is_int) begin
      dst_next = res_val[DWORD_W-1:0];
      wide_next = wide;
      high_next = (op == OP_INC) && above;
      low_next = (op == OP_DEC) && below;
      carry_next = ((op == OP_ADD) || (op == OP_SUB)) && above;
      borrow_next = ((op == OP_ADD) || (op == OP_SUB)) && below;
    end else if (op_valid && (op == OP_FDEC)) begin
      fp_neg_next = d_neg;
      fp_exp_next = d_exp;
      fp_et_next = d_exp_true;
      fp_norm_next = d_normal;
      fp_mant_next = d_mant;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dst_reg <= '0;
      valid_reg <= 1'b0;
      high_reg <= 1'b0;
      low_reg <= 1'b0;
      carry_reg <= 1'b0;
      borrow_reg <= 1'b0;
      wide_reg <= 1'b0;
      fp_neg_reg <= 1'b0;
      fp_exp_reg <= '0;
      fp_et_reg <= '0;
      fp_norm_reg <= 1'b0;
      fp_mant_reg <= '0;
    end else begin
      dst_reg <= dst_next;
      valid_reg <= valid_next;
      high_reg <= high_next;
      low_reg <= low_next;
      carry_reg <= carry_next;
      borrow_reg <= borrow_next;
      wide_reg <= wide_next;
      fp_neg_reg <= fp_neg_next;
      fp_exp_reg <= fp_exp_next;
      fp_et_reg <= fp_et_next;
      fp_norm_reg <= fp_norm_next;
      fp_mant_reg <= fp_mant_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic dst_sign;
  logic dst_zero;

  always_comb begin
    dst_sign = wide_reg ? dst_reg[SIGN32_BIT] : dst_reg[SIGN16_BIT];
    dst_zero = wide_reg ? (dst_reg == '0) : (dst_reg[WORD_W-1:0] == '0);
  end

  assign dst_lo = dst_reg[WORD_W-1:0];
  assign dst_hi = dst_reg[DWORD_W-1:WORD_W];
  assign result_valid = valid_reg;
  assign wrap_high_flag = high_reg;
  assign wrap_low_flag = low_reg;
  assign carry_flag = carry_reg;
  assign borrow_flag = borrow_reg;
  // Cascading flags for following instructions
  assign instr_flag_output = {low_reg | borrow_reg, high_reg | carry_reg,
                              dst_sign, dst_zero};
  assign fp_neg = fp_neg_reg;
  assign fp_exp = fp_exp_reg;
  assign fp_exp_true = fp_et_reg;
  assign fp_normal = fp_norm_reg;
  assign fp_mant = fp_mant_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [EXT_W-1:0] recon;

  always_comb begin
    recon = wide_reg ? {{(EXT_W-DWORD_W){dst_reg[SIGN32_BIT]}}, dst_reg}
                     : {{(EXT_W-WORD_W){dst_reg[SIGN16_BIT]}}, dst_reg[WORD_W-1:0]};
    if (carry_reg) recon = recon + (wide_reg ? WT32 : WT16);
    if (borrow_reg) recon = recon - (wide_reg ? WT32 : WT16);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_INC_WRAP16: assert property (
    op_valid && op == OP_INC && !wide && src_a_lo == POS16[15:0]
    |=> dst_lo == NEG16[15:0] && wrap_high_flag && !wrap_low_flag)
    else $error("16-bit increment did not wrap with flag");
  AST_DEC_WRAP32: assert property (
    op_valid && op == OP_DEC && wide && {src_a_hi, src_a_lo} == NEG32[31:0]
    |=> {dst_hi, dst_lo} == POS32[31:0] && wrap_low_flag)
    else $error("32-bit decrement did not wrap with flag");
  AST_TRUE_RESULT: assert property (
    op_valid && (op == OP_ADD || op == OP_SUB)
    |=> recon == $past(true_val))
    else $error("Destination plus flag weight differs from true result");
  AST_NEG_SIGN: assert property (
    op_valid && (op == OP_ADD || op == OP_SUB) && true_val[EXT_W-1]
    |=> instr_flag_output[1])
    else $error("Negative result stored with clear sign bit");
  AST_IN_RANGE_CLEAR: assert property (
    op_valid && is_int && !above && !below
    |=> !carry_flag && !borrow_flag && !wrap_high_flag && !wrap_low_flag)
    else $error("Flag left set for in-range result");
  AST_CARRY_ABOVE: assert property (
    op_valid && op == OP_ADD && !wide && src_a_lo == POS16[15:0]
    && src_b_lo == ONE34[15:0] |=> carry_flag && dst_lo == ZERO34[15:0])
    else $error("Carry missing on 16-bit add past limit");
  AST_SUB_NEGATE: assert property (
    op_valid && op == OP_SUB && !wide && src_a_lo == ZERO34[15:0]
    && src_b_lo == ONE34[15:0] |=> dst_lo == NEG16[15:0] + POS16[15:0])
    else $error("Subtract does not use two's complement negation");
  AST_BORROW_EXCL: assert property (
    borrow_flag |-> !carry_flag && instr_flag_output[3])
    else $error("Borrow not exclusive or not reported");
  AST_VALID_PULSE: assert property (
    op_valid |=> result_valid ##1 (result_valid == $past(op_valid)))
    else $error("Result strobe not one cycle after request");
  AST_NO_SPURIOUS: assert property (
    !op_valid |=> !result_valid)
    else $error("Result strobe without request");
  AST_FP_MANT: assert property (
    op_valid && op == OP_FDEC && src_a_hi[14:7] != FP_EXP_ZERO
    && src_a_hi[14:7] != FP_EXP_ALL1 |=> fp_normal && fp_mant[23])
    else $error("Normalized float lacks implied one");
  AST_FP_ZERO_EXP: assert property (
    op_valid && op == OP_FDEC && src_a_hi[14:7] == FP_EXP_ZERO
    |=> !fp_normal && fp_exp_true == -FP_BIAS)
    else $error("Zero exponent taken as normalized");

  COV_INC_WRAP: cover property (op_valid && op == OP_INC && above);
  COV_DEC_WRAP: cover property (op_valid && op == OP_DEC && below);
  COV_ADD_CARRY: cover property (op_valid && op == OP_ADD && above);
  COV_SUB_BORROW: cover property (op_valid && op == OP_SUB && below);
  COV_FP_NORMAL: cover property (op_valid && op == OP_FDEC && d_normal);

endmodule : signed_arith_flag_unit

// File: hw/arith_flag_pkg.sv
// Shared constants for the signed arithmetic and flag datapath.
// Assumes a single clock domain; all users import the whole package.
package arith_flag_pkg;

  // ----------------------------------------------------------------
  // Widths and bit positions
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int EXT_W = 34;
  localparam int SIGN16_BIT = 15;
  localparam int SIGN32_BIT = 31;

  // ----------------------------------------------------------------
  // Range limits and flag weights, sign-extended to EXT_W
  // ----------------------------------------------------------------
  localparam logic [EXT_W-1:0] POS16 = 34'h0_0000_7fff;
  localparam logic [EXT_W-1:0] NEG16 = 34'h3_ffff_8000;
  localparam logic [EXT_W-1:0] POS32 = 34'h0_7fff_ffff;
  localparam logic [EXT_W-1:0] NEG32 = 34'h3_8000_0000;
  localparam logic [EXT_W-1:0] WT16 = 34'h0_0000_8000;
  localparam logic [EXT_W-1:0] WT32 = 34'h0_8000_0000;
  localparam logic [EXT_W-1:0] ONE34 = 34'h0_0000_0001;
  localparam logic [EXT_W-1:0] ZERO34 = 34'h0_0000_0000;

  // ----------------------------------------------------------------
  // Floating-point field layout
  // ----------------------------------------------------------------
  localparam int FP_SIGN_BIT = 31;
  localparam int FP_EXP_HI = 30;
  localparam int FP_EXP_LO = 23;
  localparam int FP_FRAC_HI = 22;
  localparam logic [7:0] FP_EXP_ZERO = 8'h00;
  localparam logic [7:0] FP_EXP_ALL1 = 8'hff;
  localparam logic [9:0] FP_BIAS = 10'h07f;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INC = 3'b001,
    OP_DEC = 3'b010,
    OP_ADD = 3'b011,
    OP_SUB = 3'b100,
    OP_FDEC = 3'b101
  } op_t;

endpackage : arith_flag_pkg

// File: hw/operand_join.sv
// Joins two 16-bit words into one operand and sign-extends it.
// Assumes the words come from logic on the same clock.
`timescale 1ns/1ps
module operand_join
  import arith_flag_pkg::*;
#(
  parameter int OUT_W = EXT_W
) (
  input wire logic [WORD_W-1:0] word_lo, // Bits 15..0
  input wire logic [WORD_W-1:0] word_hi, // Bits 31..16
  input wire logic wide, // 1: 32-bit operand
  output logic [OUT_W-1:0] value // Sign-extended operand
);

  always_comb begin
    if (wide) begin
      value = {{(OUT_W-DWORD_W){word_hi[SIGN16_BIT]}}, word_hi, word_lo};
    end else begin
      value = {{(OUT_W-WORD_W){word_lo[SIGN16_BIT]}}, word_lo};
    end
  end

endmodule : operand_join

// File: hw/float_field_decode.sv
// Splits a single-precision word into its fields.
// Assumes a combinational path; the caller registers the results.
`timescale 1ns/1ps
module float_field_decode
  import arith_flag_pkg::*;
(
  input wire logic [DWORD_W-1:0] fp_word, // Packed float
  output logic neg, // Sign: 1 is negative
  output logic [7:0] exp_field, // Biased exponent
  output logic [9:0] exp_true, // Exponent minus bias
  output logic normal, // Exponent strictly inside range
  output logic [23:0] mant // Hidden one and fraction
);

  always_comb begin
    neg = fp_word[FP_SIGN_BIT];
    exp_field = fp_word[FP_EXP_HI:FP_EXP_LO];
    exp_true = {2'b00, exp_field} - FP_BIAS;
    normal = (exp_field != FP_EXP_ZERO) && (exp_field != FP_EXP_ALL1);
    mant = {normal, fp_word[FP_FRAC_HI:0]};
  end

endmodule : float_field_decode

// File: testbench/exec_side_model.sv
// Request side of the arithmetic unit: issues one operation per call.
// Assumes the caller waits for nothing; requests may run back to back.
`timescale 1ns/1ps
module exec_side_model
  import arith_flag_pkg::*;
(
  input wire logic ref_clk, // Unit clock
  output logic op_valid, // Request strobe
  output logic [2:0] op_code, // Operation
  output logic wide, // 32-bit operands
  output logic [WORD_W-1:0] src_a_lo, // Source A low
  output logic [WORD_W-1:0] src_a_hi, // Source A high
  output logic [WORD_W-1:0] src_b_lo, // Source B low
  output logic [WORD_W-1:0] src_b_hi // Source B high
);
  initial begin
    op_valid = 1'b0;
    op_code = 3'h0;
    wide = 1'b0;
    {src_a_hi, src_a_lo, src_b_hi, src_b_lo} = 64'h0;
  end

  task automatic issue(input logic [2:0] op, input logic w, input logic [31:0] a,
                       input logic [31:0] b);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= op;
    wide <= w;
    src_a_lo <= a[15:0];
    src_a_hi <= a[31:16];
    src_b_lo <= b[15:0];
    src_b_hi <= b[31:16];
  endtask : issue

  // Released operands do not hold their last value
  task automatic idle();
    @(posedge ref_clk);
    op_valid <= 1'b0;
    op_code <= ~op_code;
    {src_a_hi, src_a_lo, src_b_hi, src_b_lo} <= ~{src_a_hi, src_a_lo, src_b_hi, src_b_lo};
  endtask : idle
endmodule : exec_side_model

// File: testbench/signed_arith_flag_unit_tb.sv
// Self-checking bench for the signed arithmetic and flag unit.
// Assumes the design package and the request model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module signed_arith_flag_unit_tb
  import arith_flag_pkg::*;
;
  typedef struct packed {
    logic [31:0] dst;
    logic [3:0] fl;
    logic [3:0] ifo;
    logic [43:0] fp;
  } note_t;
  logic ref_clk, reset, op_valid, wide, result_valid;
  logic [2:0] op_code;
  logic [15:0] src_a_lo, src_a_hi, src_b_lo, src_b_hi, dst_lo, dst_hi;
  logic wrap_high_flag, wrap_low_flag, carry_flag, borrow_flag, fp_neg, fp_normal;
  logic [3:0] instr_flag_output;
  logic [7:0] fp_exp;
  logic [9:0] fp_exp_true;
  logic [23:0] fp_mant;
  logic [31:0] m_dst;
  logic [3:0] m_fl;
  logic [43:0] m_fp;
  note_t notes[$];
  int err_total, checks_done, seed;

  // ----------------------------------------------------------------
  // Clock, reset and instances
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  exec_side_model exec_side_model_i (.ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code),
    .wide(wide), .src_a_lo(src_a_lo), .src_a_hi(src_a_hi), .src_b_lo(src_b_lo),
    .src_b_hi(src_b_hi));
  signed_arith_flag_unit signed_arith_flag_unit_i (.ref_clk(ref_clk), .reset(reset),
    .op_valid(op_valid), .op_code(op_code), .wide(wide), .src_a_lo(src_a_lo),
    .src_a_hi(src_a_hi), .src_b_lo(src_b_lo), .src_b_hi(src_b_hi), .dst_lo(dst_lo),
    .dst_hi(dst_hi), .result_valid(result_valid), .wrap_high_flag(wrap_high_flag),
    .wrap_low_flag(wrap_low_flag), .carry_flag(carry_flag), .borrow_flag(borrow_flag),
    .instr_flag_output(instr_flag_output), .fp_neg(fp_neg), .fp_exp(fp_exp),
    .fp_exp_true(fp_exp_true), .fp_normal(fp_normal), .fp_mant(fp_mant));

  // ----------------------------------------------------------------
  // Reference model and driver
  // ----------------------------------------------------------------
  task automatic run(input logic [2:0] op, input logic w, input logic [31:0] a,
                     input logic [31:0] b);
    longint sa, sb, t, mx, mn, wt;
    logic [7:0] e;
    note_t nt;
    sa = w ? longint'($signed(a)) : longint'($signed(a[15:0]));
    sb = w ? longint'($signed(b)) : longint'($signed(b[15:0]));
    mx = w ? 64'sh7fffffff : 64'sh7fff;
    mn = -mx - 1;
    wt = mx + 1;
    e = a[30:23];
    if (op >= 3'h1 && op <= 3'h4) begin
      t = (op == 3'h1) ? sa + 1 : (op == 3'h2) ? sa - 1 : (op == 3'h3) ? sa + sb : sa - sb;
      m_fl = 4'h0;
      if (t > mx) begin
        m_fl = (op < 3'h3) ? 4'b1000 : 4'b0010;
        t = (op < 3'h3) ? mn : t - wt;
      end else if (t < mn) begin
        m_fl = (op < 3'h3) ? 4'b0100 : 4'b0001;
        t = (op < 3'h3) ? mx : t + wt;
      end
      m_dst = t[31:0];
    end else if (op == 3'h5) begin
      m_fp = {a[31], e, {2'b00, e} - FP_BIAS, e != 8'h00 && e != 8'hff, 1'b0, a[22:0]};
      m_fp[23] = m_fp[24];
    end
    nt.dst = m_dst;
    nt.fl = m_fl;
    nt.ifo = {m_fl[2] | m_fl[0], m_fl[3] | m_fl[1], m_dst[31], m_dst == 32'h0};
    nt.fp = m_fp;
    notes.push_back(nt);
    exec_side_model_i.issue(op, w, a, b);
  endtask : run

  function automatic logic [31:0] pick(input logic [31:0] r);
    case (r[4:2])
      3'h0: pick = 32'h7fffffff;
      3'h1: pick = 32'h80000000;
      3'h2: pick = 32'h00007fff;
      3'h3: pick = 32'hffff8000;
      default: pick = $random(seed);
    endcase
  endfunction : pick

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    note_t nt;
    if (result_valid === 1'b1) begin
      if (notes.size() == 0) begin
        err_total++;
        $display("mismatch at %0t: result without request", $time);
      end else begin
        nt = notes.pop_front();
        `CHK({dst_hi, dst_lo}, nt.dst)
        `CHK({wrap_high_flag, wrap_low_flag}, nt.fl[3:2])
        `CHK({carry_flag, borrow_flag}, nt.fl[1:0])
        `CHK(instr_flag_output, nt.ifo)
        `CHK({fp_neg, fp_exp, fp_exp_true}, nt.fp[43:25])
        `CHK({fp_normal, fp_mant}, nt.fp[24:0])
      end
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    int i;
    seed = 84104;
    err_total = 0;
    checks_done = 0;
    m_dst = 32'h0;
    m_fl = 4'h0;
    m_fp = 44'h0;
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    `CHK({dst_hi, dst_lo, instr_flag_output, result_valid}, 37'h0_0000_0002)
    run(3'h1, 1'b0, 32'h12347fff, 32'h0);
    run(3'h1, 1'b1, 32'h7fffffff, 32'h0);
    run(3'h2, 1'b0, 32'h00008000, 32'h0);
    run(3'h2, 1'b1, 32'h80000000, 32'h0);
    run(3'h3, 1'b0, 32'h00007fff, 32'h00000001);
    run(3'h4, 1'b0, 32'h00008000, 32'h00000001);
    run(3'h3, 1'b1, 32'h80000000, 32'h80000000);
    run(3'h4, 1'b1, 32'h7fffffff, 32'hffffffff);
    run(3'h3, 1'b0, 32'hffff0005, 32'h0000fffb);
    run(3'h0, 1'b1, 32'h1, 32'h1);
    run(3'h6, 1'b0, 32'h1, 32'h1);
    run(3'h5, 1'b1, 32'h3f800000, 32'h0);
    run(3'h5, 1'b1, 32'hc3fa1000, 32'h0);
    run(3'h5, 1'b1, 32'h00000001, 32'h0);
    run(3'h5, 1'b1, 32'h7f800000, 32'h0);
    exec_side_model_i.idle();
    $display("test directed done");
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      run(r[2:0], r[3], pick($random(seed)), pick($random(seed)));
      if (r[5] == 1'b1) begin
        exec_side_model_i.idle();
      end
    end
    exec_side_model_i.idle();
    $display("test random done");
    for (i = 0; i < 20 && notes.size() != 0; i++) begin
      @(posedge ref_clk);
    end
    if (notes.size() != 0) begin
      err_total++;
      $display("mismatch at %0t: results missing", $time);
    end
    tally_and_finish();
  end
endmodule : signed_arith_flag_unit_tb
